// ### hdl/cmp_cap_defines.vh
// register indices, field positions, reset values and prescale counts
`ifndef CMP_CAP_DEFINES_VH
`define CMP_CAP_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_PIN_ACTION    8'h80
`define IDX_TIMER_SETUP   8'h81
`define IDX_FREE_COUNTER  8'h82
`define IDX_COMPARE1      8'h84
`define IDX_COMPARE2      8'h86
`define IDX_COMPARE3      8'h88
`define IDX_CHANNEL4      8'h8a
`define IDX_IRQ_ENABLE    8'h8c
`define IDX_IRQ_FLAG      8'h8d

// reset values
`define RST_BYTE          8'h00
`define RST_COMPARE       16'hffff
`define RST_COUNTER       16'h0000

// timer_setup_reg fields
`define SETUP_EDGE_HI     7
`define SETUP_EDGE_LO     6
`define SETUP_DIV_HI      5
`define SETUP_DIV_LO      4
`define SETUP_EVT_HI      3
`define SETUP_EVT_LO      2
`define SETUP_HALT        1
`define SETUP_CAP_SEL     0

// flag and enable bit positions (shared by both registers)
`define BIT_MATCH1        7
`define BIT_MATCH2        6
`define BIT_MATCH3        5
`define BIT_CHANNEL4      4
`define BIT_WRAP          3
`define IMPL_BITS_MASK    8'hf8

// pin action codes
`define ACT_NONE          2'h0
`define ACT_TOGGLE        2'h1
`define ACT_LOW           2'h2
`define ACT_HIGH          2'h3

// prescaler terminal counts (ratio minus one)
`define DIV1_LAST         4'h0
`define DIV4_LAST         4'h3
`define DIV8_LAST         4'h7
`define DIV16_LAST        4'hf

`endif

// ### hdl/timer2_compare_capture_control.v
// timer channel group: compare pins, channel 4 capture, counter, flags
//
// Operation
// (R1) two-bit code picks compare pin action
// (R2) channel 4 is capture or fourth match
// (R3) edge select code picks capture trigger edge
// (R4) divider code divides internal clock 1/4/8/16
// (R5) divider and event bits written once only
// (R6) event source code picks counter clock edge
// (R7) external clock under half/quarter bus rate
// (R8) halt stops prescaler, holds counter at zero
// (R9) enable bits align with their flag bits
// (R10) flag and enable together request interrupt
// (R11) three interrupt lines: matches, ch4, wrap
// (R12) channel 4 enable follows its mode
// (R13) low three bits read zero, ignore writes
// (R14) writing one clears a flag
// (R15) match flags set on counter equality
// (R16) ch4 flag on capture edge or match
// (R17) wrap flag set on ffff to 0000
// (R18) each channel compares counter every cycle
// (R19) capture latches counter on selected edge
// (R20) match drives action on its port pin
// (R21) pin inputs synchronised then edge detected
// (R22) counter steps per tick or edge, wraps
`timescale 1ns/1ns
`include "cmp_cap_defines.vh"

module timer2_compare_capture_control (
    input  wire        sys_clk,
    input  wire        reset_n,
    input  wire [9:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output reg  [31:0] readdata,
    output reg         waitrequest,
    input  wire        ext_event_pin,
    input  wire        channel4_pin_in,
    output wire [3:0]  match_pin_out,
    output wire [3:0]  match_pin_oe,
    output reg         irq_match,
    output reg         irq_channel4,
    output reg         irq_wrap
);

    // software registers
    reg [7:0]  pin_action_reg;
    reg [7:0]  timer_setup_reg;
    reg [7:0]  irq_enable_reg;
    reg [7:0]  irq_flag_reg;
    reg [15:0] compare1_reg;
    reg [15:0] compare2_reg;
    reg [15:0] compare3_reg;
    reg [15:0] channel4_reg;
    reg        setup_locked_reg;

    // counting state
    reg [15:0] free_counter_reg;
    reg [3:0]  presc_cnt_reg;
    reg        counter_moved_reg;
    reg [3:0]  pin_level_reg;

    // pin synchronisers
    reg        ext_meta_reg;
    reg        ext_sync_reg;
    reg        ext_prev_reg;
    reg        ch4_meta_reg;
    reg        ch4_sync_reg;
    reg        ch4_prev_reg;

    wire [7:0] reg_index = address[9:2];
    wire       accept_wr = write && !waitrequest;

    // field decode
    wire [1:0] edge_sel  = {timer_setup_reg[`SETUP_EDGE_HI], timer_setup_reg[`SETUP_EDGE_LO]};
    wire [1:0] div_sel   = {timer_setup_reg[`SETUP_DIV_HI], timer_setup_reg[`SETUP_DIV_LO]};
    wire [1:0] evt_sel   = {timer_setup_reg[`SETUP_EVT_HI], timer_setup_reg[`SETUP_EVT_LO]};
    wire       counter_halt         = timer_setup_reg[`SETUP_HALT];
    wire       channel4_capture_sel = timer_setup_reg[`SETUP_CAP_SEL];

    // edge detect reads only second and third stages
    wire ext_rise = ext_sync_reg && !ext_prev_reg; // (R21)
    wire ext_fall = !ext_sync_reg && ext_prev_reg; // (R21)
    wire ch4_rise = ch4_sync_reg && !ch4_prev_reg; // (R21)
    wire ch4_fall = !ch4_sync_reg && ch4_prev_reg; // (R21)

    // prescaler terminal count
    reg [3:0] presc_last;
    always @* begin
        case (div_sel) // (R4)
            2'h0:    presc_last = `DIV1_LAST;
            2'h1:    presc_last = `DIV4_LAST;
            2'h2:    presc_last = `DIV8_LAST;
            default: presc_last = `DIV16_LAST;
        endcase
    end

    wire presc_tick = (presc_cnt_reg == presc_last);

    // counter step source; external edges rely on the far side
    // keeping its rate under half (one edge) or quarter (both)
    reg count_step;
    always @* begin
        case (evt_sel) // (R6) (R7)
            2'h0:    count_step = presc_tick;
            2'h1:    count_step = ext_rise;
            2'h2:    count_step = ext_fall;
            default: count_step = ext_rise || ext_fall;
        endcase
        if (counter_halt) begin
            count_step = 1'b0; // (R8)
        end
    end

    // capture trigger
    reg cap_edge;
    always @* begin
        case (edge_sel) // (R3)
            2'h0:    cap_edge = 1'b0;
            2'h1:    cap_edge = ch4_rise;
            2'h2:    cap_edge = ch4_fall;
            default: cap_edge = ch4_rise || ch4_fall;
        endcase
    end

    wire capture_evt = channel4_capture_sel && cap_edge; // (R2) (R19)
    wire wrap_evt    = count_step && (free_counter_reg == 16'hffff); // (R17)

    // compare against counter each cycle, only once per counter value
    wire [3:0] match_hit;
    assign match_hit[0] = counter_moved_reg && (free_counter_reg == compare1_reg); // (R18)
    assign match_hit[1] = counter_moved_reg && (free_counter_reg == compare2_reg); // (R18)
    assign match_hit[2] = counter_moved_reg && (free_counter_reg == compare3_reg); // (R18)
    assign match_hit[3] = counter_moved_reg && (free_counter_reg == channel4_reg)
                          && !channel4_capture_sel; // (R2)

    // events by flag position
    wire [7:0] flag_set = {match_hit[0], match_hit[1], match_hit[2],
                           match_hit[3] || capture_evt, wrap_evt, 3'h0}; // (R15) (R16)

    // write-one-to-clear; an event in the same cycle wins
    wire [7:0] flag_clr = (accept_wr && reg_index == `IDX_IRQ_FLAG && byteenable[0])
                          ? writedata[7:0] : 8'h00; // (R14)
    wire [7:0] flag_next = ((irq_flag_reg & ~flag_clr) | flag_set)
                           & `IMPL_BITS_MASK; // (R13)

    // pin synchronisers, two flops before any logic
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
            ch4_meta_reg <= 1'b0;
            ch4_sync_reg <= 1'b0;
            ch4_prev_reg <= 1'b0;
        end else begin
            ext_meta_reg <= ext_event_pin; // (R21)
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
            ch4_meta_reg <= channel4_pin_in; // (R21)
            ch4_sync_reg <= ch4_meta_reg;
            ch4_prev_reg <= ch4_sync_reg;
        end
    end

    // prescaler and free counter
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            presc_cnt_reg     <= 4'h0;
            free_counter_reg  <= `RST_COUNTER;
            counter_moved_reg <= 1'b0;
        end else if (counter_halt) begin
            presc_cnt_reg     <= 4'h0; // (R8)
            free_counter_reg  <= `RST_COUNTER; // (R8)
            counter_moved_reg <= 1'b0;
        end else begin
            // prescaler only runs for the internal source
            if (evt_sel != 2'h0 || presc_tick) begin
                presc_cnt_reg <= 4'h0;
            end else begin
                presc_cnt_reg <= presc_cnt_reg + 4'h1; // (R4)
            end
            counter_moved_reg <= count_step;
            if (count_step) begin
                free_counter_reg <= free_counter_reg + 16'h0001; // (R22)
            end
        end
    end

    // setup register; divider and event bits lock after first write
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_setup_reg  <= `RST_BYTE;
            setup_locked_reg <= 1'b0;
        end else if (accept_wr && reg_index == `IDX_TIMER_SETUP && byteenable[0]) begin
            setup_locked_reg <= 1'b1; // (R5)
            timer_setup_reg[7:6] <= writedata[7:6];
            timer_setup_reg[1:0] <= writedata[1:0];
            if (!setup_locked_reg) begin
                timer_setup_reg[5:2] <= writedata[5:2]; // (R5)
            end
        end
    end

    // plain control registers
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_action_reg <= `RST_BYTE;
            irq_enable_reg <= `RST_BYTE;
            irq_flag_reg   <= `RST_BYTE;
        end else begin
            irq_flag_reg <= flag_next;
            if (accept_wr && byteenable[0]) begin
                if (reg_index == `IDX_PIN_ACTION) begin
                    pin_action_reg <= writedata[7:0];
                end
                if (reg_index == `IDX_IRQ_ENABLE) begin
                    irq_enable_reg <= writedata[7:0] & `IMPL_BITS_MASK; // (R9) (R13)
                end
            end
        end
    end

    // compare value registers, byte lanes 0 and 1
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            compare1_reg <= `RST_COMPARE;
            compare2_reg <= `RST_COMPARE;
            compare3_reg <= `RST_COMPARE;
            channel4_reg <= `RST_COMPARE;
        end else begin
            if (accept_wr && reg_index == `IDX_COMPARE1) begin
                if (byteenable[0]) compare1_reg[7:0]  <= writedata[7:0];
                if (byteenable[1]) compare1_reg[15:8] <= writedata[15:8];
            end
            if (accept_wr && reg_index == `IDX_COMPARE2) begin
                if (byteenable[0]) compare2_reg[7:0]  <= writedata[7:0];
                if (byteenable[1]) compare2_reg[15:8] <= writedata[15:8];
            end
            if (accept_wr && reg_index == `IDX_COMPARE3) begin
                if (byteenable[0]) compare3_reg[7:0]  <= writedata[7:0];
                if (byteenable[1]) compare3_reg[15:8] <= writedata[15:8];
            end
            // a capture beats a software write in the same cycle
            if (capture_evt) begin
                channel4_reg <= free_counter_reg; // (R19)
            end else if (accept_wr && reg_index == `IDX_CHANNEL4) begin
                if (byteenable[0]) channel4_reg[7:0]  <= writedata[7:0];
                if (byteenable[1]) channel4_reg[15:8] <= writedata[15:8];
            end
        end
    end

    // per-channel pin action on a match
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1) begin : g_pin
            // channel 1 sits in bits 7:6, channel 4 in bits 1:0
            wire [1:0] act = pin_action_reg[7 - 2 * ch -: 2]; // (R1)
            always @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    pin_level_reg[ch] <= 1'b0;
                end else if (match_hit[ch]) begin
                    case (act) // (R1) (R20)
                        `ACT_TOGGLE: pin_level_reg[ch] <= !pin_level_reg[ch];
                        `ACT_LOW:    pin_level_reg[ch] <= 1'b0;
                        `ACT_HIGH:   pin_level_reg[ch] <= 1'b1;
                        default:     pin_level_reg[ch] <= pin_level_reg[ch];
                    endcase
                end
            end
        end
    endgenerate

    // pin drivers; channel 4 never drives while it captures
    reg [3:0] pin_oe_reg;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_oe_reg <= 4'h0;
        end else begin
            pin_oe_reg[0] <= (pin_action_reg[7:6] != `ACT_NONE); // (R20)
            pin_oe_reg[1] <= (pin_action_reg[5:4] != `ACT_NONE); // (R20)
            pin_oe_reg[2] <= (pin_action_reg[3:2] != `ACT_NONE); // (R20)
            pin_oe_reg[3] <= (pin_action_reg[1:0] != `ACT_NONE)
                             && !channel4_capture_sel; // (R2)
        end
    end

    assign match_pin_out = pin_level_reg;
    assign match_pin_oe  = pin_oe_reg;

    // interrupt lines, one cycle behind the flag register
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_match    <= 1'b0;
            irq_channel4 <= 1'b0;
            irq_wrap     <= 1'b0;
        end else begin
            irq_match    <= |(irq_flag_reg[7:5] & irq_enable_reg[7:5]); // (R10) (R11)
            irq_channel4 <= irq_flag_reg[`BIT_CHANNEL4]
                            && irq_enable_reg[`BIT_CHANNEL4]; // (R11) (R12)
            irq_wrap     <= irq_flag_reg[`BIT_WRAP]
                            && irq_enable_reg[`BIT_WRAP]; // (R10) (R11)
        end
    end

    // read mux; unmapped indices read zero
    reg [31:0] rdata_next;
    always @* begin
        rdata_next = 32'h0000_0000;
        case (reg_index)
            `IDX_PIN_ACTION:   rdata_next[7:0]  = pin_action_reg;
            `IDX_TIMER_SETUP:  rdata_next[7:0]  = timer_setup_reg;
            `IDX_FREE_COUNTER: rdata_next[15:0] = free_counter_reg;
            `IDX_COMPARE1:     rdata_next[15:0] = compare1_reg;
            `IDX_COMPARE2:     rdata_next[15:0] = compare2_reg;
            `IDX_COMPARE3:     rdata_next[15:0] = compare3_reg;
            `IDX_CHANNEL4:     rdata_next[15:0] = channel4_reg;
            `IDX_IRQ_ENABLE:   rdata_next[7:0]  = irq_enable_reg; // (R13)
            `IDX_IRQ_FLAG:     rdata_next[7:0]  = irq_flag_reg; // (R13)
            default:           rdata_next = 32'h0000_0000;
        endcase
    end

    // bus handshake: one wait cycle, then a one-cycle grant;
    // costs a cycle per access but keeps all outputs registered
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end else begin
            waitrequest <= !((read || write) && waitrequest);
            if (read && waitrequest) begin
                readdata <= rdata_next;
            end
        end
    end

endmodule // timer2_compare_capture_control

// ### sim/timer2_cc_checker.sv
// assertion checker for the compare/capture timer block
`timescale 1ns/1ns
module timer2_cc_checker (
    input wire        sys_clk,
    input wire        reset_n,
    input wire [9:0]  address,
    input wire        read,
    input wire        write,
    input wire [31:0] writedata,
    input wire [3:0]  byteenable,
    input wire [31:0] readdata,
    input wire        waitrequest,
    input wire [3:0]  match_pin_out,
    input wire [3:0]  match_pin_oe,
    input wire        irq_match,
    input wire        irq_channel4,
    input wire        irq_wrap
);
    wire [7:0] idx = address[9:2];
    wire       grant = !waitrequest && (read || write);
    wire       en_wr = grant && write && idx == 8'h8c && byteenable[0];
    reg        locked_reg;
    reg  [3:0] lock_val_reg;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // first setup write since reset fixes bits 5:2 for good
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            locked_reg <= 1'b0;
            lock_val_reg <= 4'h0;
        end else if (grant && write && idx == 8'h81 && byteenable[0] && !locked_reg) begin
            locked_reg <= 1'b1;
            lock_val_reg <= writedata[5:2];
        end
    end
    property p_grant_once;
        !waitrequest |=> waitrequest; endproperty
    a_grant_once: assert property (p_grant_once) else $error("grant longer than one cycle");
    property p_one_wait;
        (read || write) && waitrequest && !$past(read || write) |=> !waitrequest; endproperty
    a_one_wait: assert property (p_one_wait) else $error("no grant after one wait");
    property p_low_bits;
        grant && read && (idx == 8'h8c || idx == 8'h8d) |-> readdata[2:0] == 3'h0; endproperty
    a_low_bits: assert property (p_low_bits) else $error("low bits not zero");
    property p_hole;
        grant && read && idx == 8'h83 |-> readdata == 32'h0; endproperty
    a_hole: assert property (p_hole) else $error("unmapped read not zero");
    property p_lock;
        grant && read && idx == 8'h81 && locked_reg |-> readdata[5:2] == lock_val_reg; endproperty
    a_lock: assert property (p_lock) else $error("locked setup bits moved");
    property p_wrap_off;
        en_wr && !writedata[3] |=> ##1 !irq_wrap; endproperty
    a_wrap_off: assert property (p_wrap_off) else $error("wrap irq while disabled");
    property p_ch4_off;
        en_wr && !writedata[4] |=> ##1 !irq_channel4; endproperty
    a_ch4_off: assert property (p_ch4_off) else $error("ch4 irq while disabled");
    property p_match_off;
        en_wr && writedata[7:5] == 3'h0 |=> ##1 !irq_match; endproperty
    a_match_off: assert property (p_match_off) else $error("match irq while disabled");
    property p_pin_idle;
        (~match_pin_oe & ~$past(match_pin_oe) & (match_pin_out ^ $past(match_pin_out))) == 4'h0; endproperty
    a_pin_idle: assert property (p_pin_idle) else $error("idle pin moved");
    c_read: cover property (grant && read);
    c_wrap: cover property ($rose(irq_wrap));
    c_ch4: cover property ($rose(irq_channel4));
endmodule // timer2_cc_checker

bind timer2_compare_capture_control timer2_cc_checker u_timer2_cc_checker (.sys_clk, .reset_n,
    .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
    .match_pin_out, .match_pin_oe, .irq_match, .irq_channel4, .irq_wrap);

// ### sim/port_pins_model.sv
// behavioural model of the port pins facing the timer
`timescale 1ns/1ns
module port_pins_model (
    input  wire       sys_clk,
    input  wire [3:0] match_pin_out,
    input  wire [3:0] match_pin_oe,
    output reg        ext_event_pin,
    output wire       channel4_pin_in
);
    reg cap_level_reg;
    // shared pin: the timer wins while it drives it
    assign channel4_pin_in = match_pin_oe[3] ? match_pin_out[3] : cap_level_reg;
    initial begin
        ext_event_pin = 1'b0;
        cap_level_reg = 1'b0;
    end
    // eight cycles a pulse keeps the rate at an eighth of the clock, half of a quarter clock
    task make_pulses(input integer n);
        repeat (n) begin
            ext_event_pin <= 1'b1;
            repeat (4) @(posedge sys_clk);
            ext_event_pin <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
    endtask
    task set_cap(input reg v);
        cap_level_reg <= v;
    endtask
endmodule // port_pins_model

// ### sim/tb_timer2_compare_capture_control.sv
// self-checking bench for the compare/capture timer block
`timescale 1ns/1ns
module tb_timer2_compare_capture_control;
    reg         sys_clk;
    reg         reset_n;
    reg  [9:0]  address;
    reg         read;
    reg         write;
    reg  [31:0] writedata;
    reg  [3:0]  byteenable;
    wire [31:0] readdata;
    wire        waitrequest;
    wire        ext_event_pin;
    wire        channel4_pin_in;
    wire [3:0]  match_pin_out;
    wire [3:0]  match_pin_oe;
    wire        irq_match;
    wire        irq_channel4;
    wire        irq_wrap;
    integer     fail_count;
    integer     check_count;
    integer     n, e;
    reg  [31:0] lfsr_reg;
    reg  [31:0] q;
    reg  [15:0] c0;
    reg  [7:0]  a;
    timer2_compare_capture_control u_timer2_compare_capture_control (.sys_clk, .reset_n,
        .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
        .ext_event_pin, .channel4_pin_in, .match_pin_out, .match_pin_oe,
        .irq_match, .irq_channel4, .irq_wrap);
    port_pins_model u_port_pins_model (.sys_clk, .match_pin_out, .match_pin_oe,
        .ext_event_pin, .channel4_pin_in);
    // galois shift register, fixed start keeps runs repeatable
    function [31:0] lfsr_next(input [31:0] s);
        lfsr_next = {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
    endfunction
    // compare and channel 4 reset to all ones, the rest to zero
    function [31:0] rst_val(input [7:0] i);
        rst_val = (i >= 8'h84 && i <= 8'h8a && !i[0]) ? 32'h0000ffff : 32'h0;
    endfunction
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // one avalon access; holds everything until waitrequest is seen low
    task bus(input w, input [7:0] i, input [15:0] d);
        begin
            address <= {i, 2'b00};
            read <= !w;
            write <= w;
            writedata <= {16'h0, d};
            @(posedge sys_clk);
            // only the watchdog ends a wait that never sees a grant
            while (waitrequest !== 1'b0) @(posedge sys_clk);
            q = readdata;
            read <= 1'b0;
            write <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    task do_reset;
        begin
            reset_n <= 1'b0;
            repeat (8) @(posedge sys_clk);
            reset_n <= 1'b1;
            @(posedge sys_clk);
        end
    endtask
    task print_verdict;
        begin
            $display("checks=%0d mismatches=%0d", check_count, fail_count);
            if (fail_count == 0 && check_count > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // watchdog well beyond the full wrap test
    initial begin
        repeat (90000) @(posedge sys_clk);
        fail_count = fail_count + 1;
        print_verdict;
    end
    initial begin
        reset_n = 1'b0;
        address = 10'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'hf;
        fail_count = 0;
        check_count = 0;
        lfsr_reg = 32'd71367;
        @(posedge sys_clk);
        do_reset;
        // reset values and the holes between registers
        for (a = 8'h80; a <= 8'h8d; a = a + 8'h1) begin
            if (a != 8'h82) begin
                bus(1'b0, a, 16'h0);
                chk(q, rst_val(a));
            end
        end
        for (a = 8'h84; a <= 8'h8a; a = a + 8'h2) begin
            lfsr_reg = lfsr_next(lfsr_reg);
            bus(1'b1, a, lfsr_reg[15:0]);
            bus(1'b0, a, 16'h0);
            chk(q, {16'h0, lfsr_reg[15:0]});
        end
        // divide by four, halted; second write may not move the divider
        bus(1'b1, 8'h81, 16'h12);
        bus(1'b1, 8'h81, 16'h3e);
        bus(1'b0, 8'h81, 16'h0);
        chk(q, 32'h12);
        bus(1'b0, 8'h82, 16'h0);
        chk(q, 32'h0);
        for (a = 8'h84; a <= 8'h8a; a = a + 8'h2) bus(1'b1, a, 16'h10);
        bus(1'b1, 8'h80, 16'h78);
        bus(1'b1, 8'h8c, 16'hf8);
        bus(1'b1, 8'h8d, 16'hf8);
        bus(1'b1, 8'h81, 16'h10);
        bus(1'b0, 8'h82, 16'h0);
        c0 = q[15:0];
        repeat (40) @(posedge sys_clk);
        bus(1'b0, 8'h82, 16'h0);
        chk((q[15:0] - c0) >= 16'd10 && (q[15:0] - c0) <= 16'd11, 1);
        repeat (40) @(posedge sys_clk);
        bus(1'b0, 8'h8d, 16'h0);
        chk(q, 32'hf0);
        chk(match_pin_oe, 4'h7);
        chk(match_pin_out[2:0], 3'h3);
        chk({irq_match, irq_channel4, irq_wrap}, 3'h6);
        bus(1'b1, 8'h8d, 16'h87);
        bus(1'b0, 8'h8d, 16'h0);
        chk(q, 32'h70);
        bus(1'b1, 8'h8d, 16'h0);
        bus(1'b0, 8'h8d, 16'h0);
        chk(q, 32'h70);
        bus(1'b1, 8'h8c, 16'h0f);
        bus(1'b0, 8'h8c, 16'h0);
        chk(q, 32'h08);
        chk({irq_match, irq_channel4, irq_wrap}, 3'h0);
        $display("test match done");
        // event counting, then every capture edge code
        // every external edge code; write-once bits need a reset each
        for (e = 1; e < 4; e = e + 1) begin
            do_reset;
            bus(1'b1, 8'h81, {8'h0, 4'h4, e[1:0], 2'h3});
            bus(1'b0, 8'h82, 16'h0);
            chk(q, 32'h0);
            bus(1'b1, 8'h8c, 16'h10);
            bus(1'b1, 8'h81, {8'h0, 4'h4, e[1:0], 2'h1});
            lfsr_reg = lfsr_next(lfsr_reg);
            n = lfsr_reg[3:0] + 3;
            c0 = (e == 3) ? {n[14:0], 1'b0} : n[15:0];
            u_port_pins_model.make_pulses(n);
            repeat (8) @(posedge sys_clk);
            bus(1'b0, 8'h82, 16'h0);
            chk(q, {16'h0, c0});
        end
        for (e = 0; e < 4; e = e + 1) begin
            bus(1'b1, 8'h81, {8'h0, e[1:0], 6'h05});
            bus(1'b1, 8'h8d, 16'hf8);
            u_port_pins_model.set_cap(1'b1);
            repeat (10) @(posedge sys_clk);
            bus(1'b0, 8'h8d, 16'h0);
            chk(q[4], e == 1 || e == 3);
            chk(irq_channel4, e == 1 || e == 3);
            if (e == 1) begin
                bus(1'b0, 8'h8a, 16'h0);
                chk(q, {16'h0, c0});
            end
            bus(1'b1, 8'h8d, 16'hf8);
            u_port_pins_model.set_cap(1'b0);
            repeat (10) @(posedge sys_clk);
            bus(1'b0, 8'h8d, 16'h0);
            chk(q[4], e >= 2);
        end
        $display("test capture done");
        // divide by eight and sixteen over a 43-cycle span
        for (e = 2; e < 4; e = e + 1) begin
            do_reset;
            bus(1'b1, 8'h81, {10'h0, e[1:0], 4'h0});
            n = 2 << e;
            bus(1'b0, 8'h82, 16'h0);
            c0 = q[15:0];
            repeat (40) @(posedge sys_clk);
            bus(1'b0, 8'h82, 16'h0);
            chk((q[15:0] - c0) >= 43 / n && (q[15:0] - c0) <= 43 / n + 1, 1);
        end
        $display("test divider done");
        // full count at the undivided rate passes ffff
        do_reset;
        bus(1'b1, 8'h8c, 16'h08);
        bus(1'b1, 8'h81, 16'h00);
        repeat (65560) @(posedge sys_clk);
        bus(1'b0, 8'h8d, 16'h0);
        chk(q, 32'hf8);
        chk({irq_match, irq_channel4, irq_wrap}, 3'h1);
        $display("test wrap done");
        print_verdict;
    end
endmodule // tb_timer2_compare_capture_control
